// file: include/tcsir_pkg.sv
// Functional notes
// - Clear command in up or up/down mode forces the count to zero.
// - Clear command in down mode loads the count with the active top value.
// - Clear command bit reads 1 while the clear is pending, else 0.
// - Clear and start commands act only when the same write also sets channel enable.
// - Channel enable gates the channel's operating clock on and off.
// - Top value register is 16-bit read/write, reset to 0xffff.
// - Count register is read-only, resets to zero, reads the present count.
// - Status bits 7 to 2 show the levels of capture pins 5 to 0 after a two-flop synchronizer.
// - Status bits of absent capture pins always read 0.
// - Status bit 1 reads 1 counting up, 0 counting down; 1 after reset.
// - Status bit 0 reads 1 while the counter runs, 0 when idle.
// - Flag bits 13-2 hold overwrite and match flags, bit 1 top, bit 0 bottom.
// - Writing 1 clears a flag; writing 0 leaves it.
// - Flags of absent compare/capture circuits always read 0.
// - Enable register mirrors flag positions, resets 0, bits 15-14 read 0.
// - Interrupt request asserts only for a set flag whose enable is set.
// - Load-pending status shows while a new top value loads; no write then.
// - A one-shot count ending on top or bottom clears the start bit.
// - Mode 0 up, 1 down, 2 up/down, 3 reserved.
package tcsir_pkg;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MAX = 8'h04;
	localparam logic [7:0] OFF_COUNT = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;
	localparam logic [7:0] OFF_FLAGS = 8'h10;
	localparam logic [7:0] OFF_IEN = 8'h14;
	localparam int CTRL_EN = 0;
	localparam int CTRL_CLR = 1;
	localparam int CTRL_RUN = 2;
	localparam int CTRL_ONE = 3;
	localparam int CTRL_MODE = 4;
	localparam int FLAG_BOTTOM = 0;
	localparam int FLAG_TOP = 1;
	localparam int NCH = 6;
	localparam int NFLAG = 14;
	localparam logic [15:0] MAX_RST = 16'hffff;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [1:0] MAX_LOAD_CYCLES = 2'h2;
	typedef enum logic [1:0] {
		MODE_UP = 2'b00,
		MODE_DOWN = 2'b01,
		MODE_UPDN = 2'b10,
		MODE_RSVD = 2'b11
	} tcsir_mode_t;
	typedef struct packed {
		logic [NCH-1:0] overwrite;
		logic [NCH-1:0] match;
	} tcsir_evt_t;
	typedef struct packed {
		logic clk_en;
		logic running;
		logic dir_up;
		logic max_pend;
	} tcsir_stat_t;
	typedef struct packed {
		logic [NCH-1:0] cap_s1;
		logic [NCH-1:0] cap_s2;
		logic ph_act;
		logic ph_wr;
		logic [7:0] ph_addr;
		logic [31:0] rdata;
		logic hready;
		logic hresp;
		logic enable;
		logic run;
		logic oneshot;
		tcsir_mode_t mode;
		logic preset_pend;
		logic [15:0] max_sw;
		logic [15:0] max_act;
		logic max_pend;
		logic [1:0] max_cnt;
		logic [15:0] count;
		logic dir_up;
		logic [NFLAG-1:0] flags;
		logic [NFLAG-1:0] irq_en;
		logic running;
		logic irq;
	} tcsir_state_t;
endpackage : tcsir_pkg

// file: verilog/tcsir_top.sv
`timescale 1ns/100ps
module tcsir_top #(
	parameter logic [5:0] CC_PRESENT = 6'h3f
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic IRQ,
	input wire logic [tcsir_pkg::NCH-1:0] CAP_PIN,
	input wire tcsir_pkg::tcsir_evt_t EVT,
	output tcsir_pkg::tcsir_stat_t CHAN_STAT
);
	import tcsir_pkg::*;

	tcsir_state_t s;
	tcsir_state_t n;
	logic [NFLAG-1:0] flag_mask;
	logic [NFLAG-1:0] set_vec;
	logic addr_ok;
	logic wr_sel;
	logic wr_ctrl;
	logic wr_max;
	logic wr_flags;
	logic wr_ien;
	logic run_now;
	logic at_max;
	logic at_zero;
	logic top_evt;
	logic bottom_evt;

	// Absent compare/capture circuits keep their flag and enable bits at 0
	assign flag_mask[FLAG_TOP] = 1'b1;
	assign flag_mask[FLAG_BOTTOM] = 1'b1;
	assign set_vec[FLAG_TOP] = top_evt;
	assign set_vec[FLAG_BOTTOM] = bottom_evt;
	genvar m;
	generate
		for (m = 0; m < NCH; m++) begin : g_ch
			assign flag_mask[2+2*m] = CC_PRESENT[m];
			assign flag_mask[3+2*m] = CC_PRESENT[m];
			assign set_vec[2+2*m] = EVT.match[m];
			assign set_vec[3+2*m] = EVT.overwrite[m];
		end
	endgenerate

	assign addr_ok = HSEL & HREADY & HTRANS[1];
	assign wr_sel = s.ph_act & s.ph_wr;
	assign wr_ctrl = wr_sel & (s.ph_addr == OFF_CTRL);
	assign wr_max = wr_sel & (s.ph_addr == OFF_MAX);
	assign wr_flags = wr_sel & (s.ph_addr == OFF_FLAGS);
	assign wr_ien = wr_sel & (s.ph_addr == OFF_IEN);
	// Count only advances while enabled: this is the gated operating clock
	assign run_now = s.enable & s.run;
	assign at_max = s.count == s.max_act;
	assign at_zero = s.count == COUNT_RST;
	assign top_evt = run_now & at_max & (s.mode != MODE_RSVD);
	assign bottom_evt = run_now & at_zero & (s.mode != MODE_RSVD);

	function automatic logic [31:0] rd_mux(input tcsir_state_t st, input logic [7:0] a,
		input logic [5:0] cp);
		rd_mux = 32'h0;
		case (a)
			OFF_CTRL: rd_mux = {23'h0, st.max_pend, 2'h0, st.mode, st.oneshot, st.run,
				st.preset_pend, st.enable};
			OFF_MAX: rd_mux = {16'h0, st.max_sw};
			OFF_COUNT: rd_mux = {16'h0, st.count};
			OFF_STAT: rd_mux = {24'h0, st.cap_s2 & cp, st.dir_up, st.run & st.enable};
			OFF_FLAGS: rd_mux = {18'h0, st.flags};
			OFF_IEN: rd_mux = {18'h0, st.irq_en};
			default: rd_mux = 32'h0;
		endcase
	endfunction : rd_mux

	always_comb begin
		n = s;
		n.cap_s1 = CAP_PIN;
		n.cap_s2 = s.cap_s1;
		n.hready = 1'b1;
		n.hresp = 1'b0;
		n.ph_act = addr_ok;
		n.ph_wr = HWRITE;
		n.ph_addr = HADDR[7:0];
		// Read data is sampled at the address phase, served zero-wait
		n.rdata = (addr_ok & !HWRITE) ? rd_mux(s, HADDR[7:0], CC_PRESENT) : 32'h0;
		n.irq = |(s.flags & s.irq_en);
		if (s.mode == MODE_UP) begin
			n.dir_up = 1'b1;
		end else if (s.mode == MODE_DOWN) begin
			n.dir_up = 1'b0;
		end
		if (run_now) begin
			case (s.mode)
				MODE_UP: begin
					if (!at_max) begin
						n.count = s.count + 16'h1;
					end else if (s.oneshot) begin
						n.run = 1'b0;
					end else begin
						n.count = COUNT_RST;
					end
				end
				MODE_DOWN: begin
					if (!at_zero) begin
						n.count = s.count - 16'h1;
					end else if (s.oneshot) begin
						n.run = 1'b0;
					end else begin
						n.count = s.max_act;
					end
				end
				MODE_UPDN: begin
					if (s.dir_up) begin
						if (at_max) begin
							n.dir_up = 1'b0;
							n.count = s.count - 16'h1;
						end else begin
							n.count = s.count + 16'h1;
						end
					end else if (!at_zero) begin
						n.count = s.count - 16'h1;
					end else if (s.oneshot) begin
						n.run = 1'b0;
					end else begin
						n.dir_up = 1'b1;
						n.count = s.count + 16'h1;
					end
				end
				default: begin
					// Reserved mode holds the count
					n.count = s.count;
				end
			endcase
		end
		// Clear takes one enabled cycle, so the command bit is visible meanwhile
		if (s.preset_pend & s.enable) begin
			n.count = (s.mode == MODE_DOWN) ? s.max_act : COUNT_RST;
			n.preset_pend = 1'b0;
		end
		// Load only progresses while enabled; software must keep enable up
		if (s.max_pend & s.enable) begin
			if (s.max_cnt <= 2'h1) begin
				n.max_act = s.max_sw;
				n.max_pend = 1'b0;
			end else begin
				n.max_cnt = s.max_cnt - 2'h1;
			end
		end
		if (wr_ctrl) begin
			n.enable = HWDATA[CTRL_EN];
			n.mode = tcsir_mode_t'(HWDATA[CTRL_MODE+1:CTRL_MODE]);
			n.oneshot = HWDATA[CTRL_ONE];
			n.run = HWDATA[CTRL_RUN] & HWDATA[CTRL_EN];
			if (HWDATA[CTRL_CLR] & HWDATA[CTRL_EN]) begin
				n.preset_pend = 1'b1;
			end
		end
		if (wr_max) begin
			n.max_sw = HWDATA[15:0];
			n.max_pend = 1'b1;
			n.max_cnt = MAX_LOAD_CYCLES;
		end
		// Set term is ORed after the clear so a coincident event survives
		n.flags = ((s.flags & ~(wr_flags ? HWDATA[NFLAG-1:0] : 14'h0)) | set_vec)
			& flag_mask;
		if (wr_ien) begin
			n.irq_en = HWDATA[NFLAG-1:0] & flag_mask;
		end
		// Registered so the status output has no gate behind its flop
		n.running = n.run & n.enable;
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s <= '0;
			s.max_sw <= MAX_RST;
			s.max_act <= MAX_RST;
			s.count <= COUNT_RST;
			s.dir_up <= 1'b1;
			s.hready <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign HRDATA = s.rdata;
	assign HREADYOUT = s.hready;
	assign HRESP = s.hresp;
	assign IRQ = s.irq;
	assign CHAN_STAT.clk_en = s.enable;
	assign CHAN_STAT.running = s.running;
	assign CHAN_STAT.dir_up = s.dir_up;
	assign CHAN_STAT.max_pend = s.max_pend;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);

	property p_clr_zero;
		s.preset_pend && s.enable && s.mode != MODE_DOWN && !wr_ctrl |=> s.count == 16'h0;
	endproperty
	a_clr_zero: assert property (p_clr_zero) else $error("clear did not zero count");

	property p_clr_max;
		s.preset_pend && s.enable && s.mode == MODE_DOWN |=> s.count == $past(s.max_act);
	endproperty
	a_clr_max: assert property (p_clr_max) else $error("clear did not load top");

	property p_clr_bit;
		wr_ctrl && HWDATA[1] && HWDATA[0] |=> s.preset_pend ##1 (!s.preset_pend || !s.enable);
	endproperty
	a_clr_bit: assert property (p_clr_bit) else $error("clear bit sequence wrong");

	property p_run_gate;
		wr_ctrl && !HWDATA[0] |=> !s.run && (!s.preset_pend || $past(s.preset_pend && !s.enable));
	endproperty
	a_run_gate: assert property (p_run_gate) else $error("start taken while disabled");

	property p_clk_gate;
		!s.enable |=> $stable(s.count);
	endproperty
	a_clk_gate: assert property (p_clk_gate) else $error("count moved while disabled");

	property p_max_wr;
		wr_max |=> s.max_sw == $past(HWDATA[15:0]) && s.max_pend;
	endproperty
	a_max_wr: assert property (p_max_wr) else $error("top value write lost");

	property p_dir;
		s.mode == MODE_DOWN && !wr_ctrl |=> !s.dir_up;
	endproperty
	a_dir: assert property (p_dir) else $error("direction wrong in down mode");

	property p_set_wins;
		wr_flags && |(set_vec & flag_mask & HWDATA[NFLAG-1:0]) |=>
			(s.flags & $past(set_vec & flag_mask)) == $past(set_vec & flag_mask);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("coincident flag event lost");

	property p_absent;
		(s.flags & ~flag_mask) == 14'h0 && (s.irq_en & ~flag_mask) == 14'h0;
	endproperty
	a_absent: assert property (p_absent) else $error("absent channel bit set");

	property p_irq;
		IRQ == $past(|(s.flags & s.irq_en));
	endproperty
	a_irq: assert property (p_irq) else $error("irq without enabled flag");

	property p_oneshot;
		run_now && s.oneshot && s.mode == MODE_UP && at_max && !wr_ctrl |=> !s.run;
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("one-shot did not stop");

	property p_load_done;
		wr_max && s.enable |=> s.max_pend ##2 (!s.max_pend || !s.enable || wr_max);
	endproperty
	a_load_done: assert property (p_load_done) else $error("top value load stuck");

	property p_up_step;
		run_now && s.mode == MODE_UP && !at_max && !s.preset_pend |=> s.count == $past(s.count) + 16'h1;
	endproperty
	a_up_step: assert property (p_up_step) else $error("up count did not step");

	property p_down_step;
		run_now && s.mode == MODE_DOWN && !at_zero && !s.preset_pend |=> s.count == $past(s.count) - 16'h1;
	endproperty
	a_down_step: assert property (p_down_step) else $error("down count did not step");

	property p_oneshot_hold;
		run_now && s.oneshot && s.mode == MODE_UP && at_max && !s.preset_pend |=> $stable(s.count);
	endproperty
	a_oneshot_hold: assert property (p_oneshot_hold) else $error("one-shot count moved at top");

	property p_down_stop;
		run_now && s.oneshot && s.mode == MODE_DOWN && at_zero && !wr_ctrl |=> !s.run;
	endproperty
	a_down_stop: assert property (p_down_stop) else $error("one-shot down did not stop");

	property p_ien_wr;
		wr_ien |=> s.irq_en == ($past(HWDATA[NFLAG-1:0]) & flag_mask);
	endproperty
	a_ien_wr: assert property (p_ien_wr) else $error("enable write wrong");

	property p_flag_clr;
		wr_flags |=> (s.flags & $past(HWDATA[NFLAG-1:0] & ~set_vec)) == 14'h0;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared by one");

	property p_dir_up;
		s.mode == MODE_UP && !wr_ctrl |=> s.dir_up;
	endproperty
	a_dir_up: assert property (p_dir_up) else $error("direction wrong in up mode");

	property p_cnt_hold;
		s.enable && !s.run && !s.preset_pend |=> $stable(s.count);
	endproperty
	a_cnt_hold: assert property (p_cnt_hold) else $error("idle count moved");

	property p_max_hold;
		!wr_max |=> $stable(s.max_sw);
	endproperty
	a_max_hold: assert property (p_max_hold) else $error("top value changed unwritten");

	property p_run_stat;
		CHAN_STAT.running == (s.run && s.enable);
	endproperty
	a_run_stat: assert property (p_run_stat) else $error("running status wrong");
endmodule : tcsir_top

// file: testbench/tb.sv
`timescale 1ns/100ps
module tb;
	import tcsir_pkg::*;
	localparam logic [5:0] CCP = 6'h2d;
	logic CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [31:0] HWDATA = 32'h0;
	logic [2:0] HSIZE = 3'h2;
	tcsir_evt_t dp_evt = '0;
	logic [31:0] HRDATA;
	logic HREADYOUT;
	logic HRESP;
	logic IRQ;
	logic [NCH-1:0] CAP_PIN = '0;
	tcsir_evt_t EVT = '0;
	tcsir_stat_t CHAN_STAT;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	logic [31:0] seed = 32'h0bbd2a84;
	logic [31:0] rd;
	logic [31:0] r;
	logic [13:0] m_flags = '0;
	logic [13:0] m_ien;
	logic [15:0] m_max = 16'h0005;
	logic [1:0] mds [3] = '{2'h0, 2'h2, 2'h1};
	tcsir_top #(.CC_PRESENT(CCP)) i_tcsir_top (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.IRQ(IRQ), .CAP_PIN(CAP_PIN), .EVT(EVT), .CHAN_STAT(CHAN_STAT));
	always #2.5 CLK = ~CLK;
	// Bounds a hung handshake; the full run needs well under 2000 cycles
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			$display("BAD %0t timeout", $time);
			miscompares = miscompares + 1;
			stop_test();
		end
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	// Absent compare channels keep their flag and enable pairs at 0
	function automatic logic [13:0] fmask();
		logic [13:0] f;
		f = 14'h3;
		for (int m = 0; m < NCH; m++) begin
			f[2 + 2 * m] = CCP[m];
			f[3 + 2 * m] = CCP[m];
		end
		return f;
	endfunction : fmask
	function automatic logic [13:0] ebits(input tcsir_evt_t e);
		logic [13:0] f;
		f = '0;
		for (int m = 0; m < NCH; m++) begin
			f[2 + 2 * m] = e.match[m];
			f[3 + 2 * m] = e.overwrite[m];
		end
		return f;
	endfunction : ebits
	function automatic logic [31:0] stat(input logic up, input logic run);
		return {24'h0, CAP_PIN & CCP, up, run};
	endfunction : stat
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string w);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask : chk32
	task automatic chk1(input logic got, input logic exp, input string w);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s got %b exp %b", $time, w, got, exp);
		end
	endtask : chk1
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= {24'h0, a};
		HWRITE <= wr;
		HSIZE <= 3'h2;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		// Lets a flag event coincide with the data phase of this transfer
		EVT <= dp_evt;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
		EVT <= '0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk32(rd, exp, "read");
	endtask : rdc
	task automatic stop_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	initial begin
		repeat (20) @(posedge CLK);
		RESET_N <= 1'b1;
		rdc(OFF_MAX, 32'hffff);
		rdc(OFF_COUNT, 32'h0);
		rdc(OFF_FLAGS, 32'h0);
		rdc(OFF_IEN, 32'h0);
		rdc(8'h18, 32'h0);
		chk1(IRQ, 1'b0, "irq");
		$display("reset test done");
		for (int i = 0; i < 3; i++) begin
			r = xs();
			@(posedge CLK);
			CAP_PIN <= r[NCH-1:0];
			repeat (4) @(posedge CLK);
			rdc(OFF_STAT, stat(1'b1, 1'b0));
		end
		$display("status test done");
		r = xs();
		wr(OFF_IEN, r);
		m_ien = r[13:0] & fmask();
		rdc(OFF_IEN, {18'h0, m_ien});
		for (int k = 0; k < 4; k++) begin
			r = xs();
			@(posedge CLK);
			EVT <= r[11:0];
			@(posedge CLK);
			EVT <= '0;
			m_flags = m_flags | (ebits(r[11:0]) & fmask());
			repeat (2) @(posedge CLK);
			rdc(OFF_FLAGS, {18'h0, m_flags});
			chk1(IRQ, |(m_flags & m_ien), "irq");
		end
		dp_evt = '1;
		wr(OFF_FLAGS, 32'h3fff);
		dp_evt = '0;
		m_flags = ebits('1) & fmask();
		rdc(OFF_FLAGS, {18'h0, m_flags});
		wr(OFF_FLAGS, 32'h0);
		rdc(OFF_FLAGS, {18'h0, m_flags});
		wr(OFF_FLAGS, 32'hffffffff);
		rdc(OFF_FLAGS, 32'h0);
		chk1(IRQ, 1'b0, "irq");
		$display("flag test done");
		wr(OFF_CTRL, 32'h1);
		wr(OFF_MAX, {16'h0, m_max});
		#1 chk1(CHAN_STAT.max_pend, 1'b1, "pend");
		repeat (4) @(posedge CLK);
		chk1(CHAN_STAT.max_pend, 1'b0, "pend");
		rdc(OFF_MAX, {16'h0, m_max});
		wr(OFF_CTRL, 32'hd);
		#1 chk1(CHAN_STAT.running, 1'b1, "run");
		chk1(CHAN_STAT.clk_en, 1'b1, "clken");
		repeat (12) @(posedge CLK);
		rdc(OFF_CTRL, 32'h9);
		rdc(OFF_COUNT, {16'h0, m_max});
		rdc(OFF_STAT, stat(1'b1, 1'b0));
		rdc(OFF_FLAGS, 32'h3);
		chk1(IRQ, |(m_ien & 14'h3), "irq");
		wr(OFF_FLAGS, 32'h3);
		$display("one-shot test done");
		foreach (mds[j]) begin
			wr(OFF_CTRL, {26'h0, mds[j], 4'h3});
			repeat (2) @(posedge CLK);
			rdc(OFF_COUNT, (mds[j] == MODE_DOWN) ? {16'h0, m_max} : 32'h0);
			rdc(OFF_CTRL, {26'h0, mds[j], 4'h1});
			rdc(OFF_STAT, stat(mds[j] != MODE_DOWN, 1'b0));
		end
		wr(OFF_CTRL, 32'h1d);
		repeat (12) @(posedge CLK);
		rdc(OFF_CTRL, 32'h19);
		rdc(OFF_COUNT, 32'h0);
		rdc(OFF_STAT, stat(1'b0, 1'b0));
		rdc(OFF_FLAGS, 32'h3);
		wr(OFF_FLAGS, 32'h3);
		wr(OFF_CTRL, 32'h13);
		// Count now holds top, so an ignored clear stays visible
		wr(OFF_CTRL, 32'h6);
		#1 chk1(CHAN_STAT.clk_en, 1'b0, "clken");
		chk1(CHAN_STAT.running, 1'b0, "run");
		repeat (2) @(posedge CLK);
		rdc(OFF_COUNT, {16'h0, m_max});
		rdc(OFF_CTRL, 32'h0);
		$display("clear test done");
		stop_test();
	end
endmodule : tb
